// ### verilog/cladp_datapath.sv
/*
  execution datapath for 8-bit loads, 16-bit loads, push / pop and 8-bit arithmetic.
  assumes: a sequencer hands in decoded commands; memory answers with mem_ack on this clock.
*/
`default_nettype none

module cladp_datapath (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  resetn,
  input  wire logic                  ce,
  // command
  input  wire logic                  cmd_valid,
  output logic                       cmd_ready,
  input  wire cladp_pkg::cladp_cmd_t cmd,
  output logic                       done,
  // memory bus
  output logic                       mem_req,
  output logic                       mem_we,
  output logic [15:0]                mem_addr,
  output logic [7:0]                 mem_wdata,
  input  wire logic [7:0]            mem_rdata,
  input  wire logic                  mem_ack,
  // visible state
  output logic [7:0]                 acc,
  output logic                       carry_flag,
  output logic                       zero_flag,
  output logic [15:0]                sp,
  output logic [7:0]                 vec_page
);

  cladp_pkg::cladp_state_t state_q, state_d;
  cladp_pkg::cladp_cmd_t   cmd_q, cmd_d;
  logic [7:0]  gpr_q [8];
  logic [7:0]  gpr_d [8];
  logic [7:0]  vec_q, vec_d;
  logic [15:0] sp_q, sp_d, ix_q, ix_d, iy_q, iy_d;
  logic        carry_q, carry_d, zero_q, zero_d;
  logic [15:0] addr_q, addr_d, wbuf_q, wbuf_d;
  logic [7:0]  rlow_q, rlow_d;
  logic        more_q, more_d, down_q, down_d, done_q, done_d;
  logic        take;
  cladp_pkg::cladp_alu_t alu_op;
  logic [7:0]  alu_b, alu_res;
  logic        alu_c, alu_z;

  // ****************************************
  // helpers
  // ****************************************
  // read a 16-bit register pair; AF packs the two kept flags
  function automatic logic [15:0] pair_get(input cladp_pkg::cladp_pair_t p);
    logic [7:0] f;
    f = 8'h00;
    f[cladp_pkg::FLAG_C_BIT] = carry_q;
    f[cladp_pkg::FLAG_Z_BIT] = zero_q;
    unique case (p)
      cladp_pkg::P_BC: pair_get = {gpr_q[cladp_pkg::REG_B], gpr_q[cladp_pkg::REG_C]};
      cladp_pkg::P_DE: pair_get = {gpr_q[cladp_pkg::REG_D], gpr_q[cladp_pkg::REG_E]};
      cladp_pkg::P_HL: pair_get = {gpr_q[cladp_pkg::REG_H], gpr_q[cladp_pkg::REG_L]};
      cladp_pkg::P_SP: pair_get = sp_q;
      cladp_pkg::P_IX: pair_get = ix_q;
      cladp_pkg::P_IY: pair_get = iy_q;
      cladp_pkg::P_AF: pair_get = {gpr_q[cladp_pkg::REG_A], f};
      default:         pair_get = 16'h0000;
    endcase
  endfunction

  // effective address; index forms add a sign-extended displacement
  function automatic logic [15:0] eff_addr(input cladp_pkg::cladp_cmd_t c);
    logic [15:0] d;
    d = {{8{c.disp[7]}}, c.disp};
    unique case (c.am)
      cladp_pkg::AM_HL: eff_addr = pair_get(cladp_pkg::P_HL);
      cladp_pkg::AM_IX: eff_addr = ix_q + d;
      cladp_pkg::AM_IY: eff_addr = iy_q + d;
      cladp_pkg::AM_BC: eff_addr = pair_get(cladp_pkg::P_BC);
      cladp_pkg::AM_DE: eff_addr = pair_get(cladp_pkg::P_DE);
      cladp_pkg::AM_NN: eff_addr = c.imm16;
      default:          eff_addr = 16'h0000;
    endcase
  endfunction

  assign take = cmd_valid && cmd_ready && ce;
  assign cmd_ready = (state_q == cladp_pkg::ST_IDLE);

  // ****************************************
  // arithmetic unit and its operand
  // ****************************************
  // during a read the operand is the returning byte, so one unit serves all forms
  always_comb begin
    alu_op = (state_q == cladp_pkg::ST_IDLE) ? cmd.alu : cmd_q.alu;
    if (state_q == cladp_pkg::ST_READ)
      alu_b = mem_rdata;
    else if (cmd.op == cladp_pkg::OP_ALU_REG)
      alu_b = gpr_q[cmd.src];
    else if (cmd.op == cladp_pkg::OP_INCDEC_REG)
      alu_b = gpr_q[cmd.dst];
    else
      alu_b = cmd.imm8;
  end

  cladp_alu u_alu (
    .op        (alu_op),
    .a         (gpr_q[cladp_pkg::REG_A]),
    .b         (alu_b),
    .carry_in  (carry_q),
    .res       (alu_res),
    .carry_out (alu_c),
    .zero_out  (alu_z)
  );

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    logic        acc_commit;
    logic        pw;
    logic [15:0] pv;
    logic [15:0] pr;
    acc_commit = 1'b0;
    pw = 1'b0;
    pv = 16'h0000;
    pr = pair_get(cmd.pair);
    state_d = state_q;
    cmd_d = cmd_q;
    gpr_d = gpr_q;
    vec_d = vec_q;
    sp_d = sp_q;
    ix_d = ix_q;
    iy_d = iy_q;
    carry_d = carry_q;
    zero_d = zero_q;
    addr_d = addr_q;
    wbuf_d = wbuf_q;
    rlow_d = rlow_q;
    more_d = more_q;
    down_d = down_q;
    done_d = 1'b0;
    unique case (state_q)
      cladp_pkg::ST_IDLE: begin
        if (take) begin
          cmd_d = cmd;
          done_d = 1'b1;
          more_d = 1'b0;
          down_d = 1'b0;
          unique case (cmd.op)
            cladp_pkg::OP_LOAD_R_R:   gpr_d[cmd.dst] = gpr_q[cmd.src];
            cladp_pkg::OP_LOAD_R_N:   gpr_d[cmd.dst] = cmd.imm8;
            cladp_pkg::OP_LOAD_R_A:   gpr_d[cmd.dst] = gpr_q[cladp_pkg::REG_A];
            cladp_pkg::OP_LOAD_A_VEC: gpr_d[cladp_pkg::REG_A] = vec_q;
            cladp_pkg::OP_LOAD_VEC_A: vec_d = gpr_q[cladp_pkg::REG_A];
            cladp_pkg::OP_LOAD_R_MEM, cladp_pkg::OP_ALU_MEM, cladp_pkg::OP_INCDEC_MEM: begin
              done_d = 1'b0;
              state_d = cladp_pkg::ST_READ;
              addr_d = eff_addr(cmd);
            end
            cladp_pkg::OP_LOAD_MEM_R, cladp_pkg::OP_LOAD_MEM_N: begin
              done_d = 1'b0;
              state_d = cladp_pkg::ST_WRITE;
              addr_d = eff_addr(cmd);
              wbuf_d = {8'h00, (cmd.op == cladp_pkg::OP_LOAD_MEM_N) ? cmd.imm8 : gpr_q[cmd.src]};
            end
            cladp_pkg::OP_LOAD_RR_NN: begin
              pw = 1'b1;
              pv = cmd.imm16;
            end
            cladp_pkg::OP_LOAD_SP_SS: sp_d = pair_get(cmd.pair);
            cladp_pkg::OP_STORE16: begin
              done_d = 1'b0;
              state_d = cladp_pkg::ST_WRITE;
              addr_d = cmd.imm16;
              wbuf_d = pair_get(cmd.pair);
              more_d = 1'b1;
            end
            cladp_pkg::OP_LOAD16, cladp_pkg::OP_POP: begin
              done_d = 1'b0;
              state_d = cladp_pkg::ST_READ;
              more_d = 1'b1;
              addr_d = (cmd.op == cladp_pkg::OP_POP) ? sp_q : cmd.imm16;
              if (cmd.op == cladp_pkg::OP_POP)
                sp_d = sp_q + 16'h0002;
            end
            cladp_pkg::OP_PUSH: begin
              // high byte first, walking downward
              done_d = 1'b0;
              state_d = cladp_pkg::ST_WRITE;
              addr_d = sp_q - 16'h0001;
              wbuf_d = {pr[7:0], pr[15:8]};
              more_d = 1'b1;
              down_d = 1'b1;
              sp_d = sp_q - 16'h0002;
            end
            cladp_pkg::OP_ALU_REG, cladp_pkg::OP_ALU_IMM: acc_commit = 1'b1;
            cladp_pkg::OP_INCDEC_REG: begin
              gpr_d[cmd.dst] = alu_res;
              zero_d = alu_z;
            end
            cladp_pkg::OP_CARRY_INVERT: carry_d = ~carry_q;
            cladp_pkg::OP_CARRY_SET:    carry_d = 1'b1;
            default: ;
          endcase
        end
      end
      cladp_pkg::ST_READ: begin
        if (mem_ack && ce) begin
          if (more_q) begin
            rlow_d = mem_rdata;
            more_d = 1'b0;
            addr_d = addr_q + 16'h0001;
          end else begin
            state_d = cladp_pkg::ST_IDLE;
            done_d = 1'b1;
            unique case (cmd_q.op)
              cladp_pkg::OP_LOAD_R_MEM: gpr_d[cmd_q.dst] = mem_rdata;
              cladp_pkg::OP_ALU_MEM:    acc_commit = 1'b1;
              cladp_pkg::OP_INCDEC_MEM: begin
                // write the result back to the same byte
                done_d = 1'b0;
                state_d = cladp_pkg::ST_WRITE;
                wbuf_d = {8'h00, alu_res};
                zero_d = alu_z;
              end
              default: begin
                pw = 1'b1;
                pv = {mem_rdata, rlow_q};
              end
            endcase
          end
        end
      end
      cladp_pkg::ST_WRITE: begin
        if (mem_ack && ce) begin
          if (more_q) begin
            wbuf_d = {8'h00, wbuf_q[15:8]};
            more_d = 1'b0;
            addr_d = down_q ? addr_q - 16'h0001 : addr_q + 16'h0001;
          end else begin
            state_d = cladp_pkg::ST_IDLE;
            done_d = 1'b1;
          end
        end
      end
    endcase
    // arithmetic writeback shared by register, immediate and memory forms
    if (acc_commit) begin
      if (alu_op != cladp_pkg::ALU_COMPARE)
        gpr_d[cladp_pkg::REG_A] = alu_res;
      carry_d = alu_c;
      zero_d = alu_z;
    end
    // 16-bit register writeback shared by immediate, direct and stack loads
    if (pw) begin
      unique case (cmd_d.pair)
        cladp_pkg::P_BC: {gpr_d[cladp_pkg::REG_B], gpr_d[cladp_pkg::REG_C]} = pv;
        cladp_pkg::P_DE: {gpr_d[cladp_pkg::REG_D], gpr_d[cladp_pkg::REG_E]} = pv;
        cladp_pkg::P_HL: {gpr_d[cladp_pkg::REG_H], gpr_d[cladp_pkg::REG_L]} = pv;
        cladp_pkg::P_SP: sp_d = pv;
        cladp_pkg::P_IX: ix_d = pv;
        cladp_pkg::P_IY: iy_d = pv;
        cladp_pkg::P_AF: begin
          gpr_d[cladp_pkg::REG_A] = pv[15:8];
          carry_d = pv[cladp_pkg::FLAG_C_BIT];
          zero_d = pv[cladp_pkg::FLAG_Z_BIT];
        end
        default: ;
      endcase
    end
  end

  // ****************************************
  // state registers
  // ****************************************
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_q <= cladp_pkg::ST_IDLE;
      cmd_q <= '0;
      for (int i = 0; i < 8; i++)
        gpr_q[i] <= cladp_pkg::GPR_RST;
      vec_q <= cladp_pkg::VEC_RST;
      sp_q <= cladp_pkg::SP_RST;
      ix_q <= cladp_pkg::IDX_RST;
      iy_q <= cladp_pkg::IDX_RST;
      carry_q <= 1'b0;
      zero_q <= 1'b0;
      addr_q <= 16'h0000;
      wbuf_q <= 16'h0000;
      rlow_q <= 8'h00;
      more_q <= 1'b0;
      down_q <= 1'b0;
      done_q <= 1'b0;
    end else if (ce) begin
      state_q <= state_d;
      cmd_q <= cmd_d;
      gpr_q <= gpr_d;
      vec_q <= vec_d;
      sp_q <= sp_d;
      ix_q <= ix_d;
      iy_q <= iy_d;
      carry_q <= carry_d;
      zero_q <= zero_d;
      addr_q <= addr_d;
      wbuf_q <= wbuf_d;
      rlow_q <= rlow_d;
      more_q <= more_d;
      down_q <= down_d;
      done_q <= done_d;
    end
  end

  // outputs straight from state
  assign done = done_q;
  assign mem_req = (state_q != cladp_pkg::ST_IDLE);
  assign mem_we = (state_q == cladp_pkg::ST_WRITE);
  assign mem_addr = addr_q;
  assign mem_wdata = wbuf_q[7:0];
  assign acc = gpr_q[cladp_pkg::REG_A];
  assign carry_flag = carry_q;
  assign zero_flag = zero_q;
  assign sp = sp_q;
  assign vec_page = vec_q;

  // ****************************************
  // checks
  // ****************************************
  AST_LOAD_IMM: assert property (@(posedge clk) disable iff (!resetn)
    take && cmd.op == cladp_pkg::OP_LOAD_R_N |=> gpr_q[$past(cmd.dst)] == $past(cmd.imm8))
    else $error("immediate load not in register");
  AST_LOAD_FROM_ACC: assert property (@(posedge clk) disable iff (!resetn)
    take && cmd.op == cladp_pkg::OP_LOAD_R_A
      |=> gpr_q[$past(cmd.dst)] == $past(acc) && acc == $past(acc))
    else $error("accumulator copy wrong");
  AST_ACC_FROM_VEC: assert property (@(posedge clk) disable iff (!resetn)
    take && cmd.op == cladp_pkg::OP_LOAD_A_VEC |=> acc == $past(vec_page))
    else $error("vector page not in accumulator");
  AST_VEC_FROM_ACC: assert property (@(posedge clk) disable iff (!resetn)
    take && cmd.op == cladp_pkg::OP_LOAD_VEC_A |=> vec_page == $past(acc))
    else $error("accumulator not in vector page");
  AST_SP_COPY: assert property (@(posedge clk) disable iff (!resetn)
    take && cmd.op == cladp_pkg::OP_LOAD_SP_SS && cmd.pair == cladp_pkg::P_IX |=> sp == $past(ix_q))
    else $error("stack pointer copy wrong");
  AST_PUSH_HIGH: assert property (@(posedge clk) disable iff (!resetn)
    take && cmd.op == cladp_pkg::OP_PUSH
      |=> mem_we && mem_addr == $past(sp) - 16'h0001 && sp == $past(sp) - 16'h0002)
    else $error("push does not start at stack minus one");
  AST_POP_RISE: assert property (@(posedge clk) disable iff (!resetn)
    take && cmd.op == cladp_pkg::OP_POP
      |=> !mem_we && mem_addr == $past(sp) && sp == $past(sp) + 16'h0002)
    else $error("pop address or stack rise wrong");
  AST_COMPARE: assert property (@(posedge clk) disable iff (!resetn)
    take && cmd.op == cladp_pkg::OP_ALU_IMM && cmd.alu == cladp_pkg::ALU_COMPARE
      |=> acc == $past(acc) && zero_flag == ($past(acc) == $past(cmd.imm8)))
    else $error("compare changed accumulator or zero flag wrong");
  AST_ONES: assert property (@(posedge clk) disable iff (!resetn)
    take && cmd.op == cladp_pkg::OP_ALU_IMM && cmd.alu == cladp_pkg::ALU_ONES
      |=> acc == ~$past(acc))
    else $error("ones complement wrong");
  AST_CARRY_SET: assert property (@(posedge clk) disable iff (!resetn)
    take && cmd.op == cladp_pkg::OP_CARRY_SET |=> carry_flag)
    else $error("carry not forced to one");

endmodule

`default_nettype wire

// ### verilog/cladp_pkg.sv
/*
  shared types and constants of the load / stack / 8-bit arithmetic datapath.
  assumes: single clock domain, the including files compile after this one.
*/
`default_nettype none

package cladp_pkg;

  // ****************************************
  // register file layout
  // ****************************************
  localparam logic [2:0] REG_B = 3'h0;
  localparam logic [2:0] REG_C = 3'h1;
  localparam logic [2:0] REG_D = 3'h2;
  localparam logic [2:0] REG_E = 3'h3;
  localparam logic [2:0] REG_H = 3'h4;
  localparam logic [2:0] REG_L = 3'h5;
  localparam logic [2:0] REG_A = 3'h7;
  localparam int         FLAG_C_BIT = 0;
  localparam int         FLAG_Z_BIT = 6;

  // ****************************************
  // values after reset
  // ****************************************
  localparam logic [7:0]  GPR_RST = 8'h00;
  localparam logic [7:0]  VEC_RST = 8'h00;
  localparam logic [15:0] SP_RST  = 16'hffff;
  localparam logic [15:0] IDX_RST = 16'h0000;

  // ****************************************
  // commands, modes, states
  // ****************************************
  typedef enum logic [4:0] {
    OP_LOAD_R_R     = 5'b00000,
    OP_LOAD_R_N     = 5'b00001,
    OP_LOAD_R_A     = 5'b00010,
    OP_LOAD_A_VEC   = 5'b00011,
    OP_LOAD_VEC_A   = 5'b00100,
    OP_LOAD_R_MEM   = 5'b00101,
    OP_LOAD_MEM_R   = 5'b00110,
    OP_LOAD_MEM_N   = 5'b00111,
    OP_LOAD_RR_NN   = 5'b01000,
    OP_LOAD_SP_SS   = 5'b01001,
    OP_STORE16      = 5'b01010,
    OP_LOAD16       = 5'b01011,
    OP_PUSH         = 5'b01100,
    OP_POP          = 5'b01101,
    OP_ALU_REG      = 5'b01110,
    OP_ALU_IMM      = 5'b01111,
    OP_ALU_MEM      = 5'b10000,
    OP_INCDEC_REG   = 5'b10001,
    OP_INCDEC_MEM   = 5'b10010,
    OP_CARRY_INVERT = 5'b10011,
    OP_CARRY_SET    = 5'b10100
  } cladp_op_t;

  typedef enum logic [3:0] {
    ALU_ADD        = 4'b0000,
    ALU_ADD_CARRY  = 4'b0001,
    ALU_SUB        = 4'b0010,
    ALU_SUB_BORROW = 4'b0011,
    ALU_AND        = 4'b0100,
    ALU_OR         = 4'b0101,
    ALU_XOR        = 4'b0110,
    ALU_COMPARE    = 4'b0111,
    ALU_INC        = 4'b1000,
    ALU_DEC        = 4'b1001,
    ALU_ONES       = 4'b1010,
    ALU_NEGATE     = 4'b1011
  } cladp_alu_t;

  typedef enum logic [2:0] {
    AM_HL = 3'b000,
    AM_IX = 3'b001,
    AM_IY = 3'b010,
    AM_BC = 3'b011,
    AM_DE = 3'b100,
    AM_NN = 3'b101
  } cladp_am_t;

  typedef enum logic [2:0] {
    P_BC = 3'b000,
    P_DE = 3'b001,
    P_HL = 3'b010,
    P_SP = 3'b011,
    P_IX = 3'b100,
    P_IY = 3'b101,
    P_AF = 3'b110
  } cladp_pair_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_READ  = 2'b01,
    ST_WRITE = 2'b10
  } cladp_state_t;

  // one decoded instruction as handed in by the sequencer
  typedef struct packed {
    cladp_op_t   op;
    cladp_alu_t  alu;
    logic [2:0]  dst;
    logic [2:0]  src;
    cladp_pair_t pair;
    cladp_am_t   am;
    logic [7:0]  imm8;
    logic [15:0] imm16;
    logic [7:0]  disp;
  } cladp_cmd_t;

endpackage

`default_nettype wire

// ### verilog/cladp_alu.sv
/*
  8-bit arithmetic and logic unit, purely combinational.
  assumes: the caller decides which result and flags are written back.
*/
`default_nettype none

module cladp_alu (
  // operation and operands
  input  wire cladp_pkg::cladp_alu_t op,
  input  wire logic [7:0]            a,
  input  wire logic [7:0]            b,
  input  wire logic                  carry_in,
  // results
  output logic [7:0]                 res,
  output logic                       carry_out,
  output logic                       zero_out
);

  logic [8:0] wide;

  // ****************************************
  // operation select
  // ****************************************
  // carry here means borrow for the subtract forms
  always_comb begin
    wide = 9'h000;
    res = a;
    carry_out = carry_in;
    unique case (op)
      cladp_pkg::ALU_ADD:        wide = {1'b0, a} + {1'b0, b};
      cladp_pkg::ALU_ADD_CARRY:  wide = {1'b0, a} + {1'b0, b} + {8'h00, carry_in};
      cladp_pkg::ALU_SUB:        wide = {1'b0, a} - {1'b0, b};
      cladp_pkg::ALU_SUB_BORROW: wide = {1'b0, a} - {1'b0, b} - {8'h00, carry_in};
      cladp_pkg::ALU_AND:        wide = {1'b0, a & b};
      cladp_pkg::ALU_OR:         wide = {1'b0, a | b};
      cladp_pkg::ALU_XOR:        wide = {1'b0, a ^ b};
      cladp_pkg::ALU_COMPARE:    wide = {1'b0, a} - {1'b0, b};
      cladp_pkg::ALU_INC:        wide = {carry_in, b + 8'h01};
      cladp_pkg::ALU_DEC:        wide = {carry_in, b - 8'h01};
      cladp_pkg::ALU_ONES:       wide = {carry_in, ~a};
      cladp_pkg::ALU_NEGATE:     wide = 9'h000 - {1'b0, a};
      default:                   wide = 9'h000;
    endcase
    res = wide[7:0];
    carry_out = wide[8];
  end

  // compare keeps the accumulator, so its zero flag is equality, not the result
  assign zero_out = (op == cladp_pkg::ALU_COMPARE) ? (a == b) : (wide[7:0] == 8'h00);

endmodule

`default_nettype wire

// ### sim/cladp_mem_model.sv
/* memory partner: a byte array answering each mem_req after lat idle cycles.
   assumes: one clock; the datapath holds a request until it sees mem_ack. */
`default_nettype none
module cladp_mem_model (
  // bus from the datapath
  input  wire logic        clk,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [15:0] mem_addr,
  input  wire logic [7:0]  mem_wdata,
  input  wire logic [1:0]  lat,
  // answer
  output logic [7:0]       mem_rdata,
  output logic             mem_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:65535];
  logic [1:0] cnt = 2'h0;
  initial mem_ack = 1'b0;
  initial mem_rdata = 8'h00;
  // read data flips outside the ack cycle, so a stale capture cannot pass
  always @(posedge clk) begin
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (mem_req && !mem_ack) begin
      if (cnt == lat) begin
        mem_ack <= 1'b1;
        cnt <= 2'h0;
        if (mem_we) mem[mem_addr] <= mem_wdata;
        else mem_rdata <= mem[mem_addr];
      end else cnt <= cnt + 2'h1;
    end
  end
endmodule
`default_nettype wire

// ### sim/tb_top.sv
/* bench of the datapath: hand-written scenario tasks against a memory model.
   assumes: cladp_pkg and the design compile first. */
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, resetn, ce, cmd_valid, cmd_ready, done, mem_req, mem_we, mem_ack, carry_flag;
  logic zero_flag;
  logic [1:0] lat;
  logic [7:0] acc, vec_page, mem_wdata, mem_rdata;
  logic [15:0] sp, mem_addr;
  cladp_pkg::cladp_cmd_t cmd;
  int errors, cmp_count, cyc = 0;
  cladp_datapath dut_u (.clk(clk), .resetn(resetn), .ce(ce), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd(cmd), .done(done), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack),
    .acc(acc), .carry_flag(carry_flag), .zero_flag(zero_flag), .sp(sp), .vec_page(vec_page));
  cladp_mem_model mem_u (.clk(clk), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .lat(lat), .mem_rdata(mem_rdata), .mem_ack(mem_ack));
  task automatic end_sim;
    if (errors == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // one command: offered for one edge while idle, then a bounded wait for done
  task automatic ex(cladp_pkg::cladp_op_t op, cladp_pkg::cladp_alu_t a, logic [2:0] r,
      cladp_pkg::cladp_pair_t p, cladp_pkg::cladp_am_t am, logic [15:0] v);
    @(posedge clk);
    cmd <= '{op: op, alu: a, dst: r, src: r, pair: p, am: am, imm8: v[7:0], imm16: v,
             disp: v[15:8]};
    cmd_valid <= 1'b1;
    @(posedge clk);
    cmd_valid <= 1'b0;
    // done of a register op stands only in the cycle after the take edge
    #1;
    for (int n = 0; n < 40 && done !== 1'b1; n++) @(posedge clk) #1;
    `CHK({done, cmd_ready}, 2'b11)
  endtask
  task automatic ldr(logic [2:0] r, logic [7:0] v);
    ex(cladp_pkg::OP_LOAD_R_N, cladp_pkg::ALU_ADD, r, cladp_pkg::P_BC, cladp_pkg::AM_HL,
       {8'h00, v});
  endtask
  task automatic ldp(cladp_pkg::cladp_op_t op, cladp_pkg::cladp_pair_t p, logic [15:0] v);
    ex(op, cladp_pkg::ALU_ADD, cladp_pkg::REG_A, p, cladp_pkg::AM_NN, v);
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_loads;
    ldr(cladp_pkg::REG_A, 8'h3c);
    `CHK(acc, 8'h3c)
    ldp(cladp_pkg::OP_LOAD_VEC_A, cladp_pkg::P_BC, 16'h0000);
    `CHK(vec_page, 8'h3c)
    ldr(cladp_pkg::REG_A, 8'h00);
    ldp(cladp_pkg::OP_LOAD_A_VEC, cladp_pkg::P_BC, 16'h0000);
    `CHK(acc, 8'h3c)
  endtask
  // every immediate alu code except inc and dec on 3c and 0f with carry forced high first
  task automatic t_alu;
    logic [7:0] exp [12] = '{8'h4b, 8'h4c, 8'h2d, 8'h2c, 8'h0c, 8'h3f, 8'h33, 8'h3c,
                             8'h00, 8'h00, 8'hc3, 8'hc4};
    for (int i = 0; i < 12; i++) if (i < 8 || i > 9) begin
      ldr(cladp_pkg::REG_A, 8'h3c);
      ldp(cladp_pkg::OP_CARRY_SET, cladp_pkg::P_BC, 16'h0000);
      `CHK(carry_flag, 1'b1)
      ex(cladp_pkg::OP_ALU_IMM, cladp_pkg::cladp_alu_t'(i), cladp_pkg::REG_A, cladp_pkg::P_BC,
         cladp_pkg::AM_HL, 16'h000f);
      `CHK(acc, exp[i])
    end
    ldp(cladp_pkg::OP_CARRY_INVERT, cladp_pkg::P_BC, 16'h0000);
    `CHK(carry_flag, 1'b0)
    ex(cladp_pkg::OP_ALU_IMM, cladp_pkg::ALU_COMPARE, cladp_pkg::REG_A, cladp_pkg::P_BC,
       cladp_pkg::AM_HL, 16'h00c4);
    `CHK({acc, zero_flag}, 9'h189)
  endtask
  task automatic t_stack;
    ldr(cladp_pkg::REG_A, 8'h5a);
    ex(cladp_pkg::OP_LOAD_R_A, cladp_pkg::ALU_ADD, cladp_pkg::REG_B, cladp_pkg::P_BC,
       cladp_pkg::AM_HL, 16'h0000);
    ldr(cladp_pkg::REG_C, 8'ha5);
    ldp(cladp_pkg::OP_PUSH, cladp_pkg::P_BC, 16'h0000);
    `CHK({mem_u.mem[16'hfffe], mem_u.mem[16'hfffd], sp, acc}, 40'h5a_a5ff_fd5a)
    ldr(cladp_pkg::REG_A, 8'h00);
    ldp(cladp_pkg::OP_POP, cladp_pkg::P_AF, 16'h0000);
    `CHK({acc, carry_flag, zero_flag, sp}, 26'h16a_ffff)
    ex(cladp_pkg::OP_ALU_REG, cladp_pkg::ALU_SUB, cladp_pkg::REG_C, cladp_pkg::P_BC,
       cladp_pkg::AM_HL, 16'h0000);
    `CHK({acc, carry_flag}, 9'h16b)
  endtask
  // memory answers slowly here, two idle cycles per byte
  task automatic t_mem;
    lat <= 2'h2;
    ldp(cladp_pkg::OP_LOAD_RR_NN, cladp_pkg::P_HL, 16'h1234);
    ldp(cladp_pkg::OP_STORE16, cladp_pkg::P_HL, 16'h0200);
    `CHK({mem_u.mem[16'h0201], mem_u.mem[16'h0200]}, 16'h1234)
    ldp(cladp_pkg::OP_LOAD_SP_SS, cladp_pkg::P_HL, 16'h0000);
    `CHK(sp, 16'h1234)
    ldp(cladp_pkg::OP_LOAD_R_MEM, cladp_pkg::P_BC, 16'h0201);
    `CHK(acc, 8'h12)
    ldp(cladp_pkg::OP_LOAD16, cladp_pkg::P_BC, 16'h0200);
    ldp(cladp_pkg::OP_PUSH, cladp_pkg::P_BC, 16'h0000);
    `CHK({mem_u.mem[16'h1233], mem_u.mem[16'h1232], sp}, 32'h1234_1232)
    ldp(cladp_pkg::OP_LOAD_RR_NN, cladp_pkg::P_HL, 16'h0200);
    ldr(cladp_pkg::REG_A, 8'h10);
    ex(cladp_pkg::OP_ALU_MEM, cladp_pkg::ALU_ADD, cladp_pkg::REG_A, cladp_pkg::P_BC,
       cladp_pkg::AM_HL, 16'h0000);
    `CHK(acc, 8'h44)
    ex(cladp_pkg::OP_INCDEC_MEM, cladp_pkg::ALU_INC, cladp_pkg::REG_A, cladp_pkg::P_BC,
       cladp_pkg::AM_HL, 16'h0000);
    `CHK(mem_u.mem[16'h0200], 8'h35)
    ldp(cladp_pkg::OP_LOAD_RR_NN, cladp_pkg::P_IX, 16'h0210);
    ldr(cladp_pkg::REG_A, 8'h35);
    ex(cladp_pkg::OP_ALU_MEM, cladp_pkg::ALU_COMPARE, cladp_pkg::REG_A, cladp_pkg::P_BC,
       cladp_pkg::AM_IX, 16'hf000);
    `CHK({acc, zero_flag}, 9'h06b)
    ex(cladp_pkg::OP_INCDEC_REG, cladp_pkg::ALU_DEC, cladp_pkg::REG_A, cladp_pkg::P_BC,
       cladp_pkg::AM_HL, 16'h0000);
    `CHK(acc, 8'h34)
    ldp(cladp_pkg::OP_LOAD_SP_SS, cladp_pkg::P_IX, 16'h0000);
    `CHK(sp, 16'h0210)
  endtask
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // a hang is cut short well above the under two hundred cycles the run needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      end_sim;
    end
  end
  initial begin
    {resetn, cmd_valid, lat, errors, cmp_count} = '0;
    ce = 1'b1;
    cmd = '0;
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    t_loads;
    t_alu;
    t_stack;
    t_mem;
    end_sim;
  end
endmodule
`default_nettype wire
